// *** hdl/i2bf_top.sv ***
// Status-flag core of a two-wire bus controller with an APB register slave.
// Assumes open-drain SCL/SDA pins pulled up outside, pclk at 10 MHz.
//
// How it works
// (RQ1) Sending a not-acknowledge in the ack slot as receiver sets nack sent.
// (RQ2) Writing a one to the nack sent bit clears it.
// (RQ3) Module reset or processor reset clears all three flags; in module reset the code makes bus busy follow SCL low instead.
// (RQ4) A START seen on the bus or made by the block sets bus busy.
// (RQ5) Bus busy is set while SCL is low and the module is held in reset.
// (RQ6) A STOP seen on the bus or made by the block clears bus busy.
// (RQ7) Writing a one to the bus busy bit clears it.
// (RQ8) A start request while the bus is busy makes a repeated START.
// (RQ9) In master mode bus busy follows the START and STOP that software asks.
// (RQ10) A full new byte while the data register is unread sets overrun.
// (RQ11) During overrun the new byte waits in the shifter only until later bits shift over it; a read takes the shifter's last eight bits.
// (RQ12) During overrun new bits keep shifting over the held byte.
// (RQ13) Reading the receive data register clears overrun.
// (RQ14) Writing a zero to a write-one-to-clear flag leaves it alone.
// (RQ15) A hardware set beats a software clear in the same cycle.
`timescale 1ns/100ps
module i2bf_top
  import i2bf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  // Sticky flag update: set wins over clear
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  i2bf_line_if ln ();

  logic [31:0] mode_r;
  logic [31:0] mask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic scl_oe_n_r;
  logic sda_oe_n_r;
  logic nack_r;
  logic bb_r;
  logic ovr_r;
  logic rrdy_r;
  logic rx_full_r;
  logic [BYTE_W-1:0] rxdata_r;
  i2bf_seq_t seq_r;
  logic [7:0] hold_r;
  logic [BYTE_W-1:0] shift_q;
  logic byte_done;
  logic ack_drive;
  logic nack_pulse;
  logic run;
  logic wr_done;
  logic rd_done;
  logic wr_status;
  logic rd_rxdata;
  logic mapped;
  logic seq_start_made;
  logic seq_stop_made;
  logic hold_out;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign run = mode_r[MODE_RST_N_BIT];

  i2bf_line_mon u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ln(ln)
  );

  i2bf_rx_shift u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .enable(run & mode_r[MODE_RXEN_BIT]),
    .nack_mode(mode_r[MODE_NACKM_BIT]),
    .ln(ln),
    .shift_q(shift_q),
    .byte_done(byte_done),
    .ack_drive(ack_drive),
    .nack_pulse(nack_pulse)
  );

  // APB decode; one wait state, answer registered with pready
  always_comb begin
    mapped = (paddr == ADDR_MODE) || (paddr == ADDR_STATUS) ||
             (paddr == ADDR_MASK) || (paddr == ADDR_RXDATA);
    wr_done = psel & penable & pready_r & pwrite & ~pslverr_r;
    rd_done = psel & penable & pready_r & ~pwrite & ~pslverr_r;
    wr_status = wr_done & (paddr == ADDR_STATUS);
    rd_rxdata = rd_done & (paddr == ADDR_RXDATA);
  end

  always_comb begin
    status_word = '0;
    status_word[ST_NACK_BIT] = nack_r;
    status_word[ST_BB_BIT] = bb_r;
    status_word[ST_OVR_BIT] = ovr_r;
    status_word[ST_RRDY_BIT] = rrdy_r;
    unique case (paddr)
      ADDR_MODE: rd_word = mode_r;
      ADDR_STATUS: rd_word = status_word;
      ADDR_MASK: rd_word = mask_r;
      ADDR_RXDATA: rd_word = {{(32-BYTE_W){1'b0}}, rxdata_r};
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel && penable && !pready_r && !pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  // Mode register; hardware drops the request bits once the line is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RESET;
    end else if (wr_done && paddr == ADDR_MODE) begin
      mode_r <= pwdata & MODE_MASK;
    end else begin
      if (seq_start_made) begin
        mode_r[MODE_START_BIT] <= 1'b0;
      end
      if (seq_stop_made) begin
        mode_r[MODE_STOP_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RESET;
    end else if (wr_done && paddr == ADDR_MASK) begin
      mask_r <= pwdata & MASK_BITS;
    end
  end

  // START, repeated START and STOP maker, stepping every hold time
  assign hold_out = (hold_r == 8'h00);
  assign seq_start_made = (seq_r == SEQ_S_SCL) & hold_out;
  assign seq_stop_made = (seq_r == SEQ_P_REL) & hold_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= SEQ_IDLE;
      hold_r <= '0;
    end else if (!run) begin
      seq_r <= SEQ_IDLE;
      hold_r <= '0;
    end else if (seq_r == SEQ_IDLE) begin
      hold_r <= HOLD_CYC;
      if (mode_r[MODE_START_BIT]) begin
        seq_r <= bb_r ? SEQ_R_SDA : SEQ_S_SDA; // see RQ8
      end else if (mode_r[MODE_STOP_BIT]) begin
        seq_r <= SEQ_P_SDA;
      end
    end else if (!hold_out) begin
      hold_r <= hold_r - 8'h01;
    end else begin
      hold_r <= HOLD_CYC;
      unique case (seq_r)
        SEQ_R_SDA: seq_r <= SEQ_R_SCL;
        SEQ_R_SCL: seq_r <= SEQ_S_SDA;
        SEQ_S_SDA: seq_r <= SEQ_S_SCL;
        SEQ_S_SCL: seq_r <= SEQ_IDLE;
        SEQ_P_SDA: seq_r <= SEQ_P_SCL;
        SEQ_P_SCL: seq_r <= SEQ_P_REL;
        SEQ_P_REL: seq_r <= SEQ_IDLE;
        default: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // Pin drive; SCL stays low from our START to our STOP, released only for a repeated START, a module reset or a processor reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n_r <= 1'b1;
    end else if (!run) begin
      scl_oe_n_r <= 1'b1;
    end else if (seq_r == SEQ_S_SCL && hold_out) begin
      scl_oe_n_r <= 1'b0;
    end else if (seq_r == SEQ_R_SCL || seq_r == SEQ_P_SCL) begin
      scl_oe_n_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe_n_r <= 1'b1;
    end else begin
      sda_oe_n_r <= ~(ack_drive | seq_r == SEQ_S_SDA | seq_r == SEQ_S_SCL |
                      seq_r == SEQ_P_SDA | seq_r == SEQ_P_SCL);
    end
  end

  // Not-acknowledge sent flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nack_r <= 1'b0;
    end else if (!run) begin
      nack_r <= 1'b0; // see RQ3
    end else begin
      // see RQ1, RQ2, RQ14, RQ15
      nack_r <= flag_next(nack_r, nack_pulse,
                          wr_status & pwdata[ST_NACK_BIT]);
    end
  end

  // Bus busy flag; own START/STOP counted as soon as the line is made
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_r <= 1'b0;
    end else if (!run) begin
      bb_r <= ~ln.scl_lvl; // see RQ3, RQ5
    end else begin
      // see RQ4, RQ6, RQ7, RQ9, RQ14, RQ15
      bb_r <= flag_next(bb_r, ln.start_det | seq_start_made,
                        ln.stop_det | seq_stop_made |
                        (wr_status & pwdata[ST_BB_BIT]));
    end
  end

  // Receive data register and overrun; a pending byte moves on read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxdata_r <= '0;
      rx_full_r <= 1'b0;
      ovr_r <= 1'b0;
    end else if (!run) begin
      rx_full_r <= 1'b0;
      ovr_r <= 1'b0; // see RQ3
    end else if (rd_rxdata) begin
      // see RQ13; held byte or one just done takes the freed slot
      if (ovr_r || byte_done) begin
        rxdata_r <= shift_q; // see RQ11
      end
      rx_full_r <= ovr_r | byte_done;
      ovr_r <= 1'b0;
    end else if (byte_done) begin
      if (rx_full_r) begin
        ovr_r <= 1'b1; // see RQ10, RQ11
      end else begin
        rxdata_r <= shift_q;
        rx_full_r <= 1'b1;
      end
    end
  end

  // Receive ready event, cleared by write of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rrdy_r <= 1'b0;
    end else if (!run) begin
      rrdy_r <= 1'b0;
    end else begin
      rrdy_r <= flag_next(rrdy_r,
                          (byte_done & (~rx_full_r | rd_rxdata)) |
                          (rd_rxdata & ovr_r),
                          wr_status & pwdata[ST_RRDY_BIT]);
    end
  end

  // Level interrupt, one cycle behind the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_word & mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  // Open drain: the pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;
endmodule

// *** hdl/i2bf_pkg.sv ***
// Constants, register map and types for the two-wire bus status-flag block.
// Assumes a 10 MHz APB clock; the RTL modules, the checker and the testbench import this package.
package i2bf_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;

  // Mode register fields
  localparam int MODE_RST_N_BIT = 5;
  localparam int MODE_RXEN_BIT = 9;
  localparam int MODE_STOP_BIT = 11;
  localparam int MODE_START_BIT = 13;
  localparam int MODE_NACKM_BIT = 15;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK = 32'h0000_AA20;

  // Status register fields, mask register shares the layout
  localparam int ST_RRDY_BIT = 3;
  localparam int ST_OVR_BIT = 11;
  localparam int ST_BB_BIT = 12;
  localparam int ST_NACK_BIT = 13;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_BITS = 32'h0000_3808;

  // Receive byte width and acknowledge slot position
  localparam int BYTE_W = 8;
  localparam logic [3:0] LAST_BIT_CNT = 4'h7;
  localparam logic [3:0] ACK_CNT = 4'h8;

  // Hold time between line steps of START, repeated START and STOP
  localparam int CLK_MHZ = 10;
  localparam int T_HOLD_NS = 2500;
  localparam int HOLD_CYC_I = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] HOLD_CYC = 8'(HOLD_CYC_I);

  typedef enum logic [3:0] {
    SEQ_IDLE,
    SEQ_S_SDA,
    SEQ_S_SCL,
    SEQ_R_SDA,
    SEQ_R_SCL,
    SEQ_P_SDA,
    SEQ_P_SCL,
    SEQ_P_REL
  } i2bf_seq_t;

endpackage

// *** hdl/i2bf_line_if.sv ***
// Interface carrying synchronised bus line levels and events.
// Driven by the line monitor, read by the receiver and the top.
`timescale 1ns/100ps
interface i2bf_line_if;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  modport mon (
    output scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det
  );
  modport use_side (
    input scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det
  );
endinterface

// *** hdl/i2bf_line_mon.sv ***
// Line monitor: synchronises SCL and SDA, finds edges, START and STOP.
// Assumes pins are asynchronous to pclk and bus idles high.
`timescale 1ns/100ps
module i2bf_line_mon
  import i2bf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_in,
  input wire logic sda_in,
  i2bf_line_if.mon ln
);
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  assign ln.scl_lvl = scl_sync_r[1];
  assign ln.sda_lvl = sda_sync_r[1];
  assign ln.scl_rise = scl_sync_r[1] & ~scl_d_r;
  assign ln.scl_fall = ~scl_sync_r[1] & scl_d_r;
  // SDA moving while SCL stays high marks START or STOP
  assign ln.start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign ln.stop_det = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
endmodule

// *** hdl/i2bf_rx_shift.sv ***
// Receive shifter: samples SDA on SCL rise, answers the acknowledge slot.
// Assumes line events from the line monitor and one clock domain.
`timescale 1ns/100ps
module i2bf_rx_shift
  import i2bf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic nack_mode,
  i2bf_line_if.use_side ln,
  output logic [BYTE_W-1:0] shift_q,
  output logic byte_done,
  output logic ack_drive,
  output logic nack_pulse
);
  logic [BYTE_W-1:0] shift_r;
  logic [3:0] cnt_r;
  logic active_r;
  logic ack_drive_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= 1'b0;
    end else if (!enable || ln.stop_det) begin
      active_r <= 1'b0;
    end else if (ln.start_det) begin
      active_r <= 1'b1;
    end
  end

  // Shifting goes on during a transfer, even while a byte is held for overrun (see RQ12)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= '0;
      cnt_r <= '0;
    end else if (!enable || ln.start_det) begin
      cnt_r <= '0;
    end else if (active_r && ln.scl_rise) begin
      if (cnt_r == ACK_CNT) begin
        cnt_r <= '0;
      end else begin
        shift_r <= {shift_r[BYTE_W-2:0], ln.sda_lvl};
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // Ack slot: pull SDA low, or leave it released for not-acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_drive_r <= 1'b0;
      nack_pulse <= 1'b0;
    end else begin
      nack_pulse <= 1'b0;
      if (!enable || !active_r) begin
        ack_drive_r <= 1'b0;
      end else if (ln.scl_fall && cnt_r == ACK_CNT) begin
        ack_drive_r <= ~nack_mode;
        nack_pulse <= nack_mode; // see RQ1
      end else if (ln.scl_fall) begin
        ack_drive_r <= 1'b0;
      end
    end
  end

  assign byte_done = active_r & ln.scl_rise & (cnt_r == LAST_BIT_CNT);
  // Byte just completing, else the last eight bits held (see RQ11)
  assign shift_q = byte_done ? {shift_r[BYTE_W-2:0], ln.sda_lvl} : shift_r;
  assign ack_drive = ack_drive_r;
endmodule

// *** verif/i2bf_bus_model.sv ***
// Model of another master on the two-wire bus.
// Assumes open-drain lines with pull-ups; oe_n low pulls low.
`timescale 1ns/100ps
module i2bf_bus_model(
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output wire logic scl,
  output wire logic sda
);
  logic scl_pull = 1'b0;
  logic sda_pull = 1'b0;
  int starts = 0;
  int stops = 0;
  // Released lines float high through the pull-ups
  assign scl = !(scl_pull || !scl_oe_n);
  assign sda = !(sda_pull || !sda_oe_n);
  always @(negedge sda) if (scl) starts++;
  always @(posedge sda) if (scl) stops++;
  // Long low phase leaves the block time to drop its ack
  task automatic bit_cyc(input logic b, output logic s);
    #300 sda_pull = !b;
    #300 scl_pull = 1'b0;
    #100 s = sda;
    #100 scl_pull = 1'b1;
  endtask
  task automatic start();
    sda_pull = 1'b1;
    #400 scl_pull = 1'b1;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(d[i], s);
    end
    bit_cyc(1'b1, ack);
  endtask
  task automatic stop();
    #300 sda_pull = 1'b1;
    #300 scl_pull = 1'b0;
    #400 sda_pull = 1'b0;
    #400;
  endtask
endmodule

// *** verif/i2bf_top_props.sv ***
// Checker of port relations of the status-flag block.
// Assumes one pclk domain; bound into every i2bf_top.
`timescale 1ns/100ps
module i2bf_top_props
  import i2bf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  logic [31:0] mask_r;
  logic run_r;
  logic nackm_r;
  logic wr_ok;
  logic mapped;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign mapped = paddr inside {ADDR_MODE, ADDR_STATUS, ADDR_MASK,
    ADDR_RXDATA};
  // Shadow of what software last wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RESET;
      run_r <= 1'b0;
      nackm_r <= 1'b0;
    end else if (wr_ok && paddr == ADDR_MASK) begin
      mask_r <= pwdata & MASK_BITS;
    end else if (wr_ok && paddr == ADDR_MODE) begin
      run_r <= pwdata[MODE_RST_N_BIT];
      nackm_r <= pwdata[MODE_NACKM_BIT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence rd_stat_s;
    psel && penable && pready && !pwrite && paddr == ADDR_STATUS;
  endsequence
  wait_one_a: assert property (setup_s |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  bad_addr_a: assert property (pready && !mapped |-> pslverr)
    else $error("no error for unmapped address");
  rsvd_zero_a: assert property (rd_stat_s |-> (prdata & ~MASK_BITS) == 0)
    else $error("status reserved bits not zero");
  mreset_clr_a: assert property (
    rd_stat_s ##0 !run_r |-> !prdata[ST_NACK_BIT] && !prdata[ST_OVR_BIT])
    else $error("flags set while in module reset");
  idle_pins_a: assert property (
    !run_r && $past(!run_r, 2) |-> scl_oe_n && sda_oe_n)
    else $error("pins driven while in module reset");
  nack_drive_a: assert property (
    nackm_r && $past(nackm_r, 2) |-> sda_oe_n)
    else $error("data line pulled in not-ack mode");
  irq_mask_a: assert property (mask_r == 0 && $past(mask_r == 0) |-> !irq)
    else $error("interrupt while all masked");
  od_low_a: assert property (!scl_out && !sda_out)
    else $error("open-drain data not low");
endmodule
bind i2bf_top i2bf_top_props i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// *** verif/i2bf_top_tb.sv ***
// Testbench of the status-flag block with a model bus master.
// Assumes the checker is bound to i2bf_top.
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module i2bf_top_tb
  import i2bf_pkg::*;
();
  localparam logic [31:0] RUN = 32'h0000_0220;
  localparam logic [31:0] FL = 32'h0000_3800;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, err, ack;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n;
  wire scl, sda;
  logic [7:0] d [3];
  int seed, s0, bad_count = 0, checks = 0, cyc = 0, tn = 0;
  always #50 pclk = ~pclk;
  i2bf_top i_i2bf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  i2bf_bus_model i_i2bf_bus_model (.scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  function automatic logic [31:0] flags(logic n, logic b, logic o);
    return {18'h0, n, b, o, 11'h0};
  endfunction
  task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle cap here: pready ends this wait, or the bench timeout if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic poll(int b);
    int n;
    n = 0;
    do begin
      rd(ADDR_MODE);
      n++;
    end while (q[b] !== 1'b0 && n < 80);
    `CHK("request done", 1'b0, q[b])
  endtask
  task automatic test_done();
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Ceiling well above the roughly one thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    seed = 32'h991f_f04e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_STATUS);
    `CHK("status", 32'h0000_0000, q)
    rd(ADDR_MASK);
    `CHK("mask", MASK_RESET, q)
    rd(8'h10);
    `CHK("pslverr", 1'b1, err)
    i_i2bf_bus_model.scl_pull <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(ADDR_STATUS);
    `CHK("scl low busy", 1'b1, q[ST_BB_BIT])
    i_i2bf_bus_model.scl_pull <= 1'b0;
    repeat (10) @(posedge pclk);
    test_done();
    apb(1'b1, ADDR_MASK, MASK_BITS);
    apb(1'b1, ADDR_MODE, RUN);
    i_i2bf_bus_model.start();
    rd(ADDR_STATUS);
    `CHK("start busy", flags(1'b0, 1'b1, 1'b0), q & FL)
    `CHK("irq", 1'b1, irq)
    apb(1'b1, ADDR_STATUS, 32'h0000_0000);
    rd(ADDR_STATUS);
    `CHK("zero write", 1'b1, q[ST_BB_BIT])
    for (int i = 0; i < 3; i++) begin
      d[i] = 8'($random(seed));
      i_i2bf_bus_model.send(d[i], ack);
      `CHK("ack", 1'b0, ack)
      if (i == 1) begin
        rd(ADDR_STATUS);
        `CHK("overrun", 1'b1, q[ST_OVR_BIT])
      end
    end
    rd(ADDR_RXDATA);
    `CHK("held byte", {24'h0, d[0]}, q)
    rd(ADDR_STATUS);
    `CHK("overrun clear", 1'b0, q[ST_OVR_BIT])
    rd(ADDR_RXDATA);
    `CHK("last byte", {24'h0, d[2]}, q)
    i_i2bf_bus_model.stop();
    apb(1'b1, ADDR_STATUS, 32'h0000_0008);
    rd(ADDR_STATUS);
    `CHK("stop free", 32'h0000_0000, q)
    `CHK("irq off", 1'b0, irq)
    test_done();
    // Clear by one-write, module reset, then processor reset
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_MODE, RUN | 32'h0000_8000);
      i_i2bf_bus_model.start();
      i_i2bf_bus_model.send(8'($random(seed)), ack);
      `CHK("nack", 1'b1, ack)
      i_i2bf_bus_model.stop();
      rd(ADDR_STATUS);
      `CHK("nack flag", flags(1'b1, 1'b0, 1'b0), q & FL)
      rd(ADDR_RXDATA);
      if (k == 0) begin
        apb(1'b1, ADDR_STATUS, 32'h0000_2000);
      end else if (k == 1) begin
        apb(1'b1, ADDR_MODE, 32'h0000_0000);
      end else begin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
      end
      rd(ADDR_STATUS);
      `CHK("flags clear", 32'h0000_0000, q & FL)
    end
    test_done();
    s0 = i_i2bf_bus_model.starts;
    apb(1'b1, ADDR_MODE, RUN | 32'h0000_2000);
    poll(MODE_START_BIT);
    rd(ADDR_STATUS);
    `CHK("own start", 1'b1, q[ST_BB_BIT])
    apb(1'b1, ADDR_MODE, RUN | 32'h0000_2000);
    poll(MODE_START_BIT);
    `CHK("restart", s0 + 2, i_i2bf_bus_model.starts)
    rd(ADDR_STATUS);
    `CHK("restart busy", 1'b1, q[ST_BB_BIT])
    apb(1'b1, ADDR_STATUS, 32'h0000_1000);
    rd(ADDR_STATUS);
    `CHK("busy clear", 1'b0, q[ST_BB_BIT])
    // Flag cleared by hand, so this request makes a plain START
    apb(1'b1, ADDR_MODE, RUN | 32'h0000_2000);
    poll(MODE_START_BIT);
    rd(ADDR_STATUS);
    `CHK("start again", 1'b1, q[ST_BB_BIT])
    s0 = i_i2bf_bus_model.stops;
    apb(1'b1, ADDR_MODE, RUN | 32'h0000_0800);
    poll(MODE_STOP_BIT);
    `CHK("own stop", s0 + 1, i_i2bf_bus_model.stops)
    rd(ADDR_STATUS);
    `CHK("stop busy", 1'b0, q[ST_BB_BIT])
    test_done();
    end_of_test();
  end
endmodule
